/* File: rtl/pcms_top.sv */
// Purpose: Configuration and media status register with phy status, phy mode decode and irq.
// Assumes: APB slave, one clock mclk, synchronous active-low nrst.
// Notes: Phy status pins are asynchronous and pass two flip-flops.
// Function
// - Bit 31 shows phy link good.
// - Bit 30 shows 100 Mb/s rate.
// - Bit 29 shows full duplex.
// - Bit 28 reversed polarity, only at 10.
// - Bit 27 negotiation finished or inactive.
// - Bits 23-18 hold phy power-on configuration.
// - Bit 17 set: status read clears phy irq.
// - Bit 17 clear: phy irq held until cleared.
// - Bit 16 pause offer loaded from EEPROM.
// - Pause offered only with full duplex advertised.
// - Bits 15-13 selector, EEPROM loaded, read/write.
// - Even selector codes force rate and duplex.
// - Odd selector codes enable negotiation, advertise.
// - Bit 12 set: MII on, sets bit 9.
// - Register resets to all zeros.
// - Register decoded at byte offset 0004h.
// - Bit 9 holds phy in low power.
`include "pcms_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module pcms_top (
	input  wire logic                          mclk,
	input  wire logic                          nrst,
	input  wire logic                          soft_rst,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [`PCMS_ADDR_W-1:0]       paddr,
	input  wire logic [31:0]                   pwdata,
	input  wire logic [3:0]                    pstrb,
	output var  logic [31:0]                   prdata,
	output var  logic                          pready,
	output var  logic                          pslverr,
	input  wire pcms_pkg::pcms_phy_status_t    phy_status_pin,
	input  wire logic                          phy_irq_pin,
	input  wire logic                          phy_irq_manual_clear,
	input  wire logic                          irq_status_read,
	input  wire logic                          eeprom_load,
	input  wire logic [5:0]                    eeprom_phy_cfg,
	input  wire logic                          eeprom_pause,
	input  wire logic [2:0]                    eeprom_selector,
	output var  logic [5:0]                    phy_cfg,
	output var  pcms_pkg::pcms_phy_mode_t      phy_mode,
	output var  logic                          phy_power_down,
	output var  logic                          mii_enable,
	output var  logic                          phy_irq_pending,
	output var  logic                          irq
);
	pcms_pkg::pcms_phy_status_t phy_status_s;
	logic                       phy_irq_s;
	logic                       phy_irq_s_d;
	logic [31:0]                cfg_rw;
	logic [`PCMS_IRQ_W-1:0]     irq_status;
	logic [`PCMS_IRQ_W-1:0]     irq_enable;
	logic [`PCMS_IRQ_W-1:0]     irq_event;
	pcms_pkg::pcms_phy_status_t status_d;

	pcms_sync #(
		.W ($bits(pcms_pkg::pcms_phy_status_t) + 1)
	) u_sync (
		.mclk (mclk),
		.nrst (nrst),
		.din  ({phy_status_pin, phy_irq_pin}),
		.dout ({phy_status_s, phy_irq_s})
	);

	// Bus decode.
	wire        access     = psel && penable;
	wire        wr_access  = access && pwrite;
	wire        rd_access  = access && !pwrite;
	wire        hit_cfg    = (paddr == `PCMS_OFF_CFG);
	wire        hit_ists   = (paddr == `PCMS_OFF_IRQ_STATUS);
	wire        hit_ien    = (paddr == `PCMS_OFF_IRQ_ENABLE);
	wire        hit_iclr   = (paddr == `PCMS_OFF_IRQ_CLEAR);
	wire        hit_any    = hit_cfg || hit_ists || hit_ien || hit_iclr;
	wire [31:0] byte_mask  = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	wire        wr_cfg     = wr_access && hit_cfg;
	wire        wr_ien     = wr_access && hit_ien;
	wire        wr_iclr    = wr_access && hit_iclr;
	wire        rd_ists    = rd_access && hit_ists;

	wire [31:0] wr_mask    = byte_mask & `PCMS_RW_MASK;
	wire [31:0] cfg_merged = (cfg_rw & ~wr_mask) | (pwdata & wr_mask);
	wire [31:0] cfg_write  = cfg_merged | ({31'h0, cfg_merged[`PCMS_BIT_EXT]} << `PCMS_BIT_PDOWN);

	// EEPROM load of phy config, pause and selector
	wire [31:0] cfg_eeprom = {cfg_rw[31:24], eeprom_phy_cfg, cfg_rw[`PCMS_BIT_ACLR],
				  eeprom_pause, eeprom_selector, cfg_rw[12:0]};

	wire [31:0] next_cfg_rw = eeprom_load ? cfg_eeprom : (wr_cfg ? cfg_write : cfg_rw);

	// zero on hard and soft reset
	always_ff @(posedge mclk) begin
		if (!nrst || soft_rst) begin
			cfg_rw <= `PCMS_CFG_RESET;
		end else begin
			cfg_rw <= next_cfg_rw;
		end
	end

	wire        pol_bit   = phy_status_s.pair_reversed && !phy_status_s.rate_hundred;
	wire [4:0]  stat_bits = {phy_status_s.link_good, phy_status_s.rate_hundred,
				 phy_status_s.full_duplex, pol_bit, phy_status_s.autoneg_done};
	// bits 26-24 and 11 read zero
	wire [31:0] cfg_read  = {stat_bits, 3'h0, cfg_rw[23:12], 1'b0, cfg_rw[10:0]};

	wire [2:0]  sel       = cfg_rw[`PCMS_SEL_HI:`PCMS_SEL_LO];
	// forced modes when lowest bit zero
	wire        force_100 = sel[1];
	wire        force_fd  = sel[2];
	// advertise set when lowest bit one
	logic [3:0] adv;
	always_comb begin
		unique case (pcms_pkg::pcms_sel_t'(sel))
			pcms_pkg::PCMS_SEL_A10HF: adv = 4'h3;
			pcms_pkg::PCMS_SEL_A_HD:  adv = 4'h5;
			pcms_pkg::PCMS_SEL_A100:  adv = 4'hC;
			pcms_pkg::PCMS_SEL_A_ALL: adv = 4'hF;
			default:                  adv = 4'h0;
		endcase
	end
	wire        fd_adv    = adv[1] || adv[3];
	wire        pause_ok  = cfg_rw[`PCMS_BIT_PAUSE] && sel[0] && fd_adv;

	pcms_pkg::pcms_phy_mode_t next_mode;
	assign next_mode = '{autoneg_enable: sel[0], force_hundred: force_100 && !sel[0],
			     force_full: force_fd && !sel[0], advertise: adv, pause_offer: pause_ok};

	// Phy irq and status change events feed the local interrupt.
	wire        irq_rise  = phy_irq_s && !phy_irq_s_d;
	assign irq_event = {irq_rise, status_d.autoneg_done != phy_status_s.autoneg_done,
			    status_d.rate_hundred != phy_status_s.rate_hundred,
			    status_d.link_good != phy_status_s.link_good};
	// read of status clears phy irq when bit 17 set
	wire        auto_clr  = rd_ists && cfg_rw[`PCMS_BIT_ACLR];
	wire        phy_clr   = auto_clr || phy_irq_manual_clear;
	wire        next_phy_pending = irq_rise || (phy_irq_pending && !phy_clr);

	wire [`PCMS_IRQ_W-1:0] clr_bits     = wr_iclr ? pwdata[`PCMS_IRQ_W-1:0] : `PCMS_IRQ_RESET;
	wire [`PCMS_IRQ_W-1:0] next_ists    = irq_event | (irq_status & ~clr_bits);
	wire [`PCMS_IRQ_W-1:0] next_ien     = wr_ien ? pwdata[`PCMS_IRQ_W-1:0] : irq_enable;

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		if (hit_cfg) begin
			rd_mux = cfg_read;
		end else if (hit_ists) begin
			rd_mux = {28'h0, irq_status};
		end else if (hit_ien) begin
			rd_mux = {28'h0, irq_enable};
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			phy_irq_s_d     <= 1'b0;
			status_d        <= '0;
			irq_status      <= `PCMS_IRQ_RESET;
			irq_enable      <= `PCMS_IRQ_RESET;
			phy_irq_pending <= 1'b0;
			irq             <= 1'b0;
		end else begin
			phy_irq_s_d     <= phy_irq_s;
			status_d        <= phy_status_s;
			irq_status      <= next_ists;
			irq_enable      <= next_ien;
			phy_irq_pending <= next_phy_pending;
			irq             <= |(next_ists & next_ien);
		end
	end

	// Outputs registered; pready answers in the setup cycle's next edge.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			prdata         <= 32'h00000000;
			pready         <= 1'b0;
			pslverr        <= 1'b0;
			phy_cfg        <= 6'h00;
			phy_mode       <= '0;
			phy_power_down <= 1'b0;
			mii_enable     <= 1'b0;
		end else begin
			pready         <= psel && !penable;
			pslverr        <= psel && !penable && !hit_any;
			prdata         <= (psel && !penable && !pwrite) ? rd_mux : prdata;
			phy_cfg        <= cfg_rw[`PCMS_PHYCFG_HI:`PCMS_PHYCFG_LO];
			phy_mode       <= next_mode;
			phy_power_down <= cfg_rw[`PCMS_BIT_PDOWN];
			mii_enable     <= cfg_rw[`PCMS_BIT_EXT];
		end
	end
endmodule
`default_nettype wire

/* File: rtl/pcms_defs.svh */
// Purpose: Offsets, field positions, reset values and codes of the media config/status block.
// Assumes: 32-bit APB data, byte addresses.
// Notes: Definitions only.
`ifndef PCMS_DEFS_SVH
`define PCMS_DEFS_SVH

`define PCMS_ADDR_W          12
`define PCMS_OFF_CFG         12'h004
`define PCMS_OFF_IRQ_STATUS  12'h040
`define PCMS_OFF_IRQ_ENABLE  12'h044
`define PCMS_OFF_IRQ_CLEAR   12'h048
`define PCMS_CFG_RESET       32'h00000000
`define PCMS_BIT_LINK        31
`define PCMS_BIT_RATE        30
`define PCMS_BIT_FDX         29
`define PCMS_BIT_POL         28
`define PCMS_BIT_ANDONE      27
`define PCMS_PHYCFG_HI       23
`define PCMS_PHYCFG_LO       18
`define PCMS_BIT_ACLR        17
`define PCMS_BIT_PAUSE       16
`define PCMS_SEL_HI          15
`define PCMS_SEL_LO          13
`define PCMS_BIT_EXT         12
`define PCMS_BIT_PDOWN       9
`define PCMS_RW_MASK         32'h00FFF3FF
`define PCMS_IRQ_W           4
`define PCMS_IRQ_RESET       4'h0

`endif

/* File: rtl/pcms_pkg.sv */
// Purpose: Types shared by the media config/status block.
// Assumes: Nothing beyond the defs header.
// Notes: Selector codes are three bits, lowest bit enables negotiation.
package pcms_pkg;

	typedef enum logic [2:0] {
		PCMS_SEL_F10H  = 3'h0,
		PCMS_SEL_A10HF = 3'h1,
		PCMS_SEL_F100H = 3'h2,
		PCMS_SEL_A_HD  = 3'h3,
		PCMS_SEL_F10F  = 3'h4,
		PCMS_SEL_A100  = 3'h5,
		PCMS_SEL_F100F = 3'h6,
		PCMS_SEL_A_ALL = 3'h7
	} pcms_sel_t;

	typedef struct packed {
		logic link_good;
		logic rate_hundred;
		logic full_duplex;
		logic pair_reversed;
		logic autoneg_done;
	} pcms_phy_status_t;

	typedef struct packed {
		logic       autoneg_enable;
		logic       force_hundred;
		logic       force_full;
		logic [3:0] advertise;
		logic       pause_offer;
	} pcms_phy_mode_t;

endpackage

/* File: rtl/pcms_sync.sv */
// Purpose: Two-flop synchroniser for a bus of pin levels.
// Assumes: Inputs are quasi-static levels.
// Notes: First stage is read only by the second stage.
`timescale 1ns/100ps
`default_nettype none
module pcms_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);
	logic [W-1:0] stage1;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			stage1 <= '0;
			dout   <= '0;
		end else begin
			stage1 <= din;
			dout   <= stage1;
		end
	end
endmodule
`default_nettype wire

/* File: verification/pcms_checker.sv */
// Purpose: Port assertions for the media config/status block.
// Assumes: Zero-wait APB, outputs follow the register one edge later.
// Notes: Bound into every pcms_top.
`include "pcms_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module pcms_checker (
	input wire logic                     mclk,
	input wire logic                     nrst,
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pwrite,
	input wire logic [11:0]              paddr,
	input wire logic [31:0]              pwdata,
	input wire logic [3:0]               pstrb,
	input wire logic [31:0]              prdata,
	input wire logic                     pready,
	input wire logic                     pslverr,
	input wire logic                     phy_irq_manual_clear,
	input wire logic                     eeprom_load,
	input wire logic [5:0]               eeprom_phy_cfg,
	input wire logic [2:0]               eeprom_selector,
	input wire logic [5:0]               phy_cfg,
	input wire pcms_pkg::pcms_phy_mode_t phy_mode,
	input wire logic                     phy_power_down,
	input wire logic                     mii_enable,
	input wire logic                     phy_irq_pending
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire setup = psel && !penable;
	wire known = paddr == `PCMS_OFF_CFG || paddr == `PCMS_OFF_IRQ_STATUS
		|| paddr == `PCMS_OFF_IRQ_ENABLE || paddr == `PCMS_OFF_IRQ_CLEAR;
	wire clr = phy_irq_manual_clear || (psel && !pwrite && paddr == `PCMS_OFF_IRQ_STATUS);
	function automatic logic [3:0] adv(input logic [2:0] s);
		case (s)
			3'h1: adv = 4'h3;
			3'h3: adv = 4'h5;
			3'h5: adv = 4'hC;
			default: adv = 4'hF;
		endcase
	endfunction
	sequence s_cfg_wr;
		psel && penable && pready && pwrite && paddr == `PCMS_OFF_CFG && pstrb[1];
	endsequence
	property p_ready; setup |=> pready; endproperty
	property p_slverr; setup && !known |=> pslverr && (pwrite || prdata == 32'h0); endproperty
	property p_reset;
		@(posedge mclk) disable iff (1'b0) !nrst |=> prdata == 32'h0 && !mii_enable
			&& !phy_power_down && phy_cfg == 6'h0 && !phy_irq_pending;
	endproperty
	property p_pause;
		phy_mode.pause_offer |-> phy_mode.autoneg_enable
			&& (phy_mode.advertise[3] || phy_mode.advertise[1]);
	endproperty
	property p_pend; $fell(phy_irq_pending) |-> $past(clr) || $past(clr, 2); endproperty
	property p_pdown; s_cfg_wr ##0 pwdata[9] |=> ##1 phy_power_down; endproperty
	property p_ext; s_cfg_wr ##0 pwdata[12] |=> ##1 mii_enable && phy_power_down; endproperty
	property p_ee;
		logic [5:0] c;
		logic [2:0] s;
		(eeprom_load, c = eeprom_phy_cfg, s = eeprom_selector)
			|=> ##1 phy_cfg == c && phy_mode.autoneg_enable == s[0];
	endproperty
	property p_mode;
		logic [2:0] s;
		(eeprom_load, s = eeprom_selector) |=> ##1 (s[0] ? phy_mode.advertise == adv(s)
			: {phy_mode.force_hundred, phy_mode.force_full} == {s[1], s[2]});
	endproperty
	a_ready: assert property (p_ready) else $error("ready not in access cycle");
	a_slverr: assert property (p_slverr) else $error("unmapped access accepted");
	a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
	a_pause: assert property (p_pause) else $error("pause offered without full duplex");
	a_pend: assert property (p_pend) else $error("phy irq dropped with no clear");
	a_pdown: assert property (p_pdown) else $error("power down not set");
	a_ext: assert property (p_ext) else $error("external phy mode wrong");
	a_ee: assert property (p_ee) else $error("eeprom load not applied");
	a_mode: assert property (p_mode) else $error("selector decode wrong");
endmodule
bind pcms_top pcms_checker u_pcms_checker (.mclk, .nrst, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .prdata, .pready, .pslverr, .phy_irq_manual_clear, .eeprom_load,
	.eeprom_phy_cfg, .eeprom_selector, .phy_cfg, .phy_mode, .phy_power_down, .mii_enable,
	.phy_irq_pending);
`default_nettype wire

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the media config/status block.
// Assumes: Zero-wait APB slave, synchronous reset.
// Notes: Inputs change by NBA after a rising edge.
`include "pcms_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic mclk, nrst, soft_rst, psel, penable, pwrite, pready, pslverr, serr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [3:0] pstrb;
	pcms_pkg::pcms_phy_status_t phy_status_pin;
	pcms_pkg::pcms_phy_mode_t phy_mode;
	logic phy_irq_pin, phy_irq_manual_clear, eeprom_load, eeprom_pause;
	logic [5:0] eeprom_phy_cfg, phy_cfg;
	logic [2:0] eeprom_selector;
	logic phy_power_down, mii_enable, phy_irq_pending, irq;
	logic [3:0] adv_tab [8] = '{4'h0, 4'h3, 4'h0, 4'h5, 4'h0, 4'hC, 4'h0, 4'hF};
	logic [4:0] pats [4] = '{5'h13, 5'h0D, 5'h1C, 5'h1A};
	logic [4:0] pexp [4] = '{5'h13, 5'h0D, 5'h1C, 5'h18};
	int n_errors = 0;
	int compares = 0;
	pcms_top u_pcms_top (.mclk, .nrst, .soft_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .phy_status_pin, .phy_irq_pin,
		.phy_irq_manual_clear, .irq_status_read(1'b0), .eeprom_load, .eeprom_phy_cfg,
		.eeprom_pause, .eeprom_selector, .phy_cfg, .phy_mode, .phy_power_down, .mii_enable,
		.phy_irq_pending, .irq);
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic report_and_stop;
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1 && ++n < 50);
		rdat = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) n_errors++;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hF);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, 4'hF);
		cmp(rdat, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask
	initial begin
		{nrst, soft_rst, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{phy_status_pin, phy_irq_pin, phy_irq_manual_clear, eeprom_load} = '0;
		{eeprom_pause, eeprom_phy_cfg, eeprom_selector} = '0;
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		rd(`PCMS_OFF_CFG, 32'h0);
		rd(12'h0FC, 32'h0);
		cmp(serr, 1'b1);
		$display("reset and decode test done");
		foreach (pats[i]) begin
			@(posedge mclk) phy_status_pin <= pats[i];
			cyc(5);
			rd(`PCMS_OFF_CFG, {pexp[i], 27'h0});
		end
		@(posedge mclk) phy_status_pin <= '0;
		cyc(5);
		wr(`PCMS_OFF_CFG, 32'hFFFFFBFF);
		cyc(2);
		rd(`PCMS_OFF_CFG, 32'h00FFF3FF);
		cmp({phy_cfg, mii_enable, phy_power_down}, 8'hFF);
		apb(1'b1, `PCMS_OFF_CFG, 32'h0, 4'h4);
		rd(`PCMS_OFF_CFG, 32'h0000F3FF);
		wr(`PCMS_OFF_CFG, 32'h00001000);
		cyc(2);
		rd(`PCMS_OFF_CFG, 32'h00001200);
		cmp({mii_enable, phy_power_down}, 2'h3);
		wr(`PCMS_OFF_CFG, 32'h0);
		cyc(2);
		cmp({mii_enable, phy_power_down}, 2'h0);
		$display("status and control test done");
		for (int i = 0; i < 8; i++) begin
			wr(`PCMS_OFF_CFG, 32'h10000 | (i << 13));
			cyc(2);
			rd(`PCMS_OFF_CFG, 32'h10000 | (i << 13));
			cmp(phy_mode.autoneg_enable, i[0]);
			cmp(phy_mode.pause_offer, adv_tab[i][3] | adv_tab[i][1]);
			if (i[0])
				cmp(phy_mode.advertise, adv_tab[i]);
			else
				cmp({phy_mode.force_hundred, phy_mode.force_full}, {i[1], i[2]});
		end
		@(posedge mclk) {eeprom_load, eeprom_phy_cfg, eeprom_pause, eeprom_selector} <= 11'h6AF;
		@(posedge mclk) eeprom_load <= 1'b0;
		cyc(2);
		rd(`PCMS_OFF_CFG, 32'h00A9E000);
		cmp({phy_cfg, phy_mode.pause_offer}, 7'h55);
		@(posedge mclk) soft_rst <= 1'b1;
		@(posedge mclk) soft_rst <= 1'b0;
		cyc(2);
		rd(`PCMS_OFF_CFG, 32'h0);
		$display("selector and load test done");
		wr(`PCMS_OFF_IRQ_CLEAR, 32'hF);
		wr(`PCMS_OFF_IRQ_ENABLE, 32'h8);
		@(posedge mclk) phy_irq_pin <= 1'b1;
		cyc(4);
		cmp({phy_irq_pending, irq}, 2'h3);
		rd(`PCMS_OFF_IRQ_STATUS, 32'h8);
		cyc(1);
		cmp(phy_irq_pending, 1'b1);
		wr(`PCMS_OFF_IRQ_CLEAR, 32'h8);
		cyc(2);
		cmp(irq, 1'b0);
		@(posedge mclk) phy_irq_manual_clear <= 1'b1;
		@(posedge mclk) phy_irq_manual_clear <= 1'b0;
		cyc(2);
		cmp(phy_irq_pending, 1'b0);
		wr(`PCMS_OFF_CFG, 32'h20000);
		@(posedge mclk) phy_irq_pin <= 1'b0;
		cyc(3);
		@(posedge mclk) phy_irq_pin <= 1'b1;
		cyc(4);
		wr(`PCMS_OFF_IRQ_ENABLE, 32'h0);
		cyc(2);
		cmp({phy_irq_pending, irq}, 2'h2);
		rd(`PCMS_OFF_IRQ_STATUS, 32'h8);
		cyc(2);
		cmp(phy_irq_pending, 1'b0);
		$display("interrupt test done");
		report_and_stop;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		report_and_stop;
	end
endmodule
`default_nettype wire
